//--- dmi_decoder.sv
// Top of the drive macro input decoder: inputs to run, direction, reference and relays.
`timescale 1ns/10ps
`default_nettype none
module dmi_decoder (
  // Clock, reset and enable.
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  // Configuration.
  input wire logic [2:0] macro_sel,
  input wire logic vector_ctrl,
  // Raw terminals.
  input wire logic digital_input_one,
  input wire logic digital_input_two,
  input wire logic digital_input_three,
  input wire logic digital_input_four,
  input wire logic digital_input_five,
  input wire logic digital_input_six,
  input wire logic [1:0] safe_torque_off_inputs,
  input wire logic [dmi_pkg::DMI_REF_W-1:0] analog_reference_input,
  // Reference parameters.
  input wire logic [dmi_pkg::DMI_REF_W-1:0] const_freq1,
  input wire logic [dmi_pkg::DMI_REF_W-1:0] const_freq2,
  input wire logic [dmi_pkg::DMI_REF_W-1:0] const_freq3,
  input wire logic [dmi_pkg::DMI_REF_W-1:0] const_speed1,
  input wire logic [dmi_pkg::DMI_REF_W-1:0] const_speed2,
  input wire logic [dmi_pkg::DMI_REF_W-1:0] const_speed3,
  // Ramp parameters.
  input wire logic [dmi_pkg::DMI_REF_W-1:0] freq_acc_time1,
  input wire logic [dmi_pkg::DMI_REF_W-1:0] freq_dec_time1,
  input wire logic [dmi_pkg::DMI_REF_W-1:0] freq_acc_time2,
  input wire logic [dmi_pkg::DMI_REF_W-1:0] freq_dec_time2,
  input wire logic [dmi_pkg::DMI_REF_W-1:0] speed_acc_time1,
  input wire logic [dmi_pkg::DMI_REF_W-1:0] speed_dec_time1,
  input wire logic [dmi_pkg::DMI_REF_W-1:0] speed_acc_time2,
  input wire logic [dmi_pkg::DMI_REF_W-1:0] speed_dec_time2,
  // Motor potentiometer configuration.
  input wire logic [dmi_pkg::DMI_STEP_W-1:0] pot_step_period,
  input wire logic [dmi_pkg::DMI_REF_W-1:0] pot_step_size,
  input wire logic [dmi_pkg::DMI_REF_W-1:0] pot_ref_min,
  input wire logic [dmi_pkg::DMI_REF_W-1:0] pot_ref_max,
  // Drive status.
  input wire logic drive_ready,
  input wire logic motor_running,
  input wire logic drive_fault,
  // Commands.
  output logic run_cmd_ff,
  output logic reverse_ff,
  output logic [1:0] ref_src_ff,
  output logic [dmi_pkg::DMI_REF_W-1:0] reference_ff,
  output logic ramp_set2_ff,
  output logic [dmi_pkg::DMI_REF_W-1:0] acc_time_ff,
  output logic [dmi_pkg::DMI_REF_W-1:0] dec_time_ff,
  // Relays.
  output logic ready_relay,
  output logic running_relay,
  output logic fault_relay
);

  ////////////////////////////////////////////////////////////////////////////
  // Input conditioning.

  logic [dmi_pkg::DMI_NUM_DI-1:0] di_raw;
  logic [dmi_pkg::DMI_NUM_DI-1:0] di;
  logic [dmi_pkg::DMI_NUM_DI-1:0] di_prev_ff;
  logic [dmi_pkg::DMI_NUM_DI-1:0] di_rise;
  logic [dmi_pkg::DMI_REF_W-1:0] pot_ref;
  dmi_pkg::dmi_macro_t macro;
  logic sto_ok;
  logic three_wire_ff;

  assign di_raw = {digital_input_six, digital_input_five, digital_input_four,
                   digital_input_three, digital_input_two, digital_input_one};
  assign macro = dmi_pkg::dmi_macro_t'(macro_sel);
  assign sto_ok = &safe_torque_off_inputs;

  // One filter per digital input, so their contact bounce never reaches the decoder; the safe torque off inputs are unfiltered.
  genvar gi;
  generate
    for (gi = 0; gi < dmi_pkg::DMI_NUM_DI; gi++) begin : g_deb
      dmi_debounce u_deb (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .clk_en(clk_en),
        .raw_in(di_raw[gi]),
        .clean_ff(di[gi])
      );
    end
  endgenerate

  // Previous filtered levels for pulse detection.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      di_prev_ff <= dmi_pkg::DMI_DI_RST;
    end else if (clk_en) begin
      di_prev_ff <= di;
    end
  end

  assign di_rise = di & ~di_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Two select bits in table order (first bit is constant 1) to a source code.
  function automatic dmi_pkg::dmi_ref_src_t sel_decode(input logic lo, input logic hi);
    sel_decode = dmi_pkg::dmi_ref_src_t'({hi, lo});
  endfunction : sel_decode

  // Constant frequency in scalar control, constant speed in vector control.
  function automatic logic [dmi_pkg::DMI_REF_W-1:0] pick(input logic vec,
      input logic [dmi_pkg::DMI_REF_W-1:0] freq_v,
      input logic [dmi_pkg::DMI_REF_W-1:0] speed_v);
    pick = vec ? speed_v : freq_v;
  endfunction : pick

  ////////////////////////////////////////////////////////////////////////////
  // Motor potentiometer store.

  dmi_pot_ref u_pot (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clk_en(clk_en),
    .active(macro == dmi_pkg::DMI_MACRO_MOTOR_POT),
    .ref_up(di[dmi_pkg::DMI_DI3]),
    .ref_down(di[dmi_pkg::DMI_DI4]),
    .step_period(pot_step_period),
    .step_size(pot_step_size),
    .ref_min(pot_ref_min),
    .ref_max(pot_ref_max),
    .pot_ref_ff(pot_ref)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 3-wire run latch.

  // Stop pulse wins over start pulse; latch also drops when the mode changes.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      three_wire_ff <= 1'b0;
    end else if (clk_en) begin
      if (macro != dmi_pkg::DMI_MACRO_THREE_WIRE || di_rise[dmi_pkg::DMI_DI2]) begin
        three_wire_ff <= 1'b0;
      end else if (di_rise[dmi_pkg::DMI_DI1] && sto_ok) begin
        three_wire_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Macro decode.

  logic nxt_run;
  logic nxt_rev;
  dmi_pkg::dmi_ref_src_t nxt_src;
  logic nxt_ramp2;
  logic use_pot;

  always_comb begin
    nxt_run = 1'b0;
    nxt_rev = 1'b0;
    nxt_src = dmi_pkg::DMI_REF_ANALOG;
    nxt_ramp2 = 1'b0;
    use_pot = 1'b0;
    unique case (macro)
      dmi_pkg::DMI_MACRO_STANDARD: begin
        nxt_run = di[dmi_pkg::DMI_DI1];
        nxt_rev = di[dmi_pkg::DMI_DI2];
        nxt_src = sel_decode(di[dmi_pkg::DMI_DI3], di[dmi_pkg::DMI_DI4]);
        nxt_ramp2 = di[dmi_pkg::DMI_DI5];
      end
      dmi_pkg::DMI_MACRO_THREE_WIRE: begin
        nxt_run = three_wire_ff;
        nxt_rev = di[dmi_pkg::DMI_DI3];
        nxt_src = sel_decode(di[dmi_pkg::DMI_DI4], di[dmi_pkg::DMI_DI5]);
      end
      dmi_pkg::DMI_MACRO_ALTERNATE: begin
        nxt_run = (di[dmi_pkg::DMI_DI1] ^ di[dmi_pkg::DMI_DI2]) &&
                  di[dmi_pkg::DMI_DI6];
        nxt_rev = di[dmi_pkg::DMI_DI2] && !di[dmi_pkg::DMI_DI1];
        nxt_src = sel_decode(di[dmi_pkg::DMI_DI3], di[dmi_pkg::DMI_DI4]);
        nxt_ramp2 = di[dmi_pkg::DMI_DI5];
      end
      dmi_pkg::DMI_MACRO_MOTOR_POT: begin
        nxt_run = di[dmi_pkg::DMI_DI1] && di[dmi_pkg::DMI_DI6];
        nxt_rev = di[dmi_pkg::DMI_DI2];
        use_pot = !di[dmi_pkg::DMI_DI5];
        nxt_src = di[dmi_pkg::DMI_DI5] ? dmi_pkg::DMI_REF_CONST1 :
                  dmi_pkg::DMI_REF_ANALOG;
      end
      default: begin
        // Unused codes select no macro and keep the motor stopped.
        nxt_run = 1'b0;
      end
    endcase
    // Safe torque off gates every start.
    if (!sto_ok) begin
      nxt_run = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered commands.

  // Run and direction.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      run_cmd_ff <= 1'b0;
      reverse_ff <= 1'b0;
    end else if (clk_en) begin
      run_cmd_ff <= nxt_run;
      reverse_ff <= nxt_rev;
    end
  end

  // Reference source and value; in pot mode analog means the stored value.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ref_src_ff <= 2'h0;
      reference_ff <= '0;
    end else if (clk_en) begin
      ref_src_ff <= nxt_src;
      unique case (nxt_src)
        dmi_pkg::DMI_REF_ANALOG:
          reference_ff <= use_pot ? pot_ref : analog_reference_input;
        dmi_pkg::DMI_REF_CONST1:
          reference_ff <= pick(vector_ctrl, const_freq1, const_speed1);
        dmi_pkg::DMI_REF_CONST2:
          reference_ff <= pick(vector_ctrl, const_freq2, const_speed2);
        dmi_pkg::DMI_REF_CONST3:
          reference_ff <= pick(vector_ctrl, const_freq3, const_speed3);
      endcase
    end
  end

  // Ramp set and its times.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ramp_set2_ff <= 1'b0;
      acc_time_ff <= '0;
      dec_time_ff <= '0;
    end else if (clk_en) begin
      ramp_set2_ff <= nxt_ramp2;
      if (nxt_ramp2) begin
        acc_time_ff <= pick(vector_ctrl, freq_acc_time2, speed_acc_time2);
        dec_time_ff <= pick(vector_ctrl, freq_dec_time2, speed_dec_time2);
      end else begin
        acc_time_ff <= pick(vector_ctrl, freq_acc_time1, speed_acc_time1);
        dec_time_ff <= pick(vector_ctrl, freq_dec_time1, speed_dec_time1);
      end
    end
  end

  // Relays; the fault relay is fail-safe so it drops on a fault.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ready_relay <= 1'b0;
      running_relay <= 1'b0;
      fault_relay <= 1'b0;
    end else if (clk_en) begin
      ready_relay <= drive_ready;
      running_relay <= motor_running;
      fault_relay <= !drive_fault;
    end
  end

endmodule : dmi_decoder
`default_nettype wire

//--- dmi_pkg.sv
// Package of constants and types for the drive macro input decoder.
package dmi_pkg;

  // Macro selection codes.
  typedef enum logic [2:0] {
    DMI_MACRO_STANDARD = 3'h0,
    DMI_MACRO_THREE_WIRE = 3'h1,
    DMI_MACRO_ALTERNATE = 3'h2,
    DMI_MACRO_MOTOR_POT = 3'h3
  } dmi_macro_t;

  // Reference source selection codes.
  typedef enum logic [1:0] {
    DMI_REF_ANALOG = 2'h0,
    DMI_REF_CONST1 = 2'h1,
    DMI_REF_CONST2 = 2'h2,
    DMI_REF_CONST3 = 2'h3
  } dmi_ref_src_t;

  // Widths and counts.
  localparam int DMI_NUM_DI = 6;
  localparam int DMI_REF_W = 16;
  localparam int DMI_DEB_W = 8;
  localparam int DMI_STEP_W = 16;

  // Clock and debounce time; the cycle count is derived from them.
  localparam int DMI_CLK_MHZ = 100;
  localparam int DMI_DEBOUNCE_US = 1;
  localparam logic [DMI_DEB_W-1:0] DMI_DEB_CYCLES =
    DMI_DEB_W'(DMI_DEBOUNCE_US * DMI_CLK_MHZ);

  // Reset values.
  localparam logic [DMI_REF_W-1:0] DMI_POT_RST = 16'h0000;
  localparam logic [DMI_NUM_DI-1:0] DMI_DI_RST = 6'h00;

  // Digital input positions.
  localparam int DMI_DI1 = 0;
  localparam int DMI_DI2 = 1;
  localparam int DMI_DI3 = 2;
  localparam int DMI_DI4 = 3;
  localparam int DMI_DI5 = 4;
  localparam int DMI_DI6 = 5;

endpackage : dmi_pkg

//--- dmi_debounce.sv
// Two-stage synchroniser and stable-count debouncer for one digital input.
`timescale 1ns/10ps
`default_nettype none
module dmi_debounce (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  // Raw and filtered level.
  input wire logic raw_in,
  output logic clean_ff
);

  logic meta_ff;
  logic sync_ff;
  logic [dmi_pkg::DMI_DEB_W-1:0] cnt_ff;

  // Synchroniser; the first stage feeds only the second.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else if (clk_en) begin
      meta_ff <= raw_in;
      sync_ff <= meta_ff;
    end
  end

  // Output follows only after the level held for the full debounce time.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= '0;
      clean_ff <= 1'b0;
    end else if (clk_en) begin
      if (sync_ff == clean_ff) begin
        cnt_ff <= '0;
      end else if (cnt_ff == dmi_pkg::DMI_DEB_CYCLES - 8'h01) begin
        cnt_ff <= '0;
        clean_ff <= sync_ff;
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end

endmodule : dmi_debounce
`default_nettype wire

//--- dmi_pot_ref.sv
// Motor potentiometer reference store with rate stepping and clamping.
`timescale 1ns/10ps
`default_nettype none
module dmi_pot_ref (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  // Commands.
  input wire logic active,
  input wire logic ref_up,
  input wire logic ref_down,
  // Configuration.
  input wire logic [dmi_pkg::DMI_STEP_W-1:0] step_period,
  input wire logic [dmi_pkg::DMI_REF_W-1:0] step_size,
  input wire logic [dmi_pkg::DMI_REF_W-1:0] ref_min,
  input wire logic [dmi_pkg::DMI_REF_W-1:0] ref_max,
  // Stored value.
  output logic [dmi_pkg::DMI_REF_W-1:0] pot_ref_ff
);

  logic [dmi_pkg::DMI_STEP_W-1:0] tick_cnt_ff;
  logic tick;
  logic [dmi_pkg::DMI_REF_W:0] sum;
  logic [dmi_pkg::DMI_REF_W:0] dif;
  logic [dmi_pkg::DMI_REF_W-1:0] nxt_pot_ref;
  logic moving;

  // Moves only for exactly one of up and down; both or neither holds.
  assign moving = active && (ref_up ^ ref_down);

  // Rate generator; restarts whenever no move is requested.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_ff <= '0;
    end else if (clk_en) begin
      if (!moving || tick) begin
        tick_cnt_ff <= '0;
      end else begin
        tick_cnt_ff <= tick_cnt_ff + 16'h0001;
      end
    end
  end

  assign tick = moving && (tick_cnt_ff >= step_period);
  assign sum = {1'b0, pot_ref_ff} + {1'b0, step_size};
  assign dif = {1'b0, pot_ref_ff} - {1'b0, step_size};

  // Step and clamp between the configured limits.
  always_comb begin
    nxt_pot_ref = pot_ref_ff;
    if (tick && ref_up) begin
      nxt_pot_ref = (sum[dmi_pkg::DMI_REF_W] || sum[dmi_pkg::DMI_REF_W-1:0] > ref_max) ?
        ref_max : sum[dmi_pkg::DMI_REF_W-1:0];
    end else if (tick && ref_down) begin
      nxt_pot_ref = (dif[dmi_pkg::DMI_REF_W] || dif[dmi_pkg::DMI_REF_W-1:0] < ref_min) ?
        ref_min : dif[dmi_pkg::DMI_REF_W-1:0];
    end
  end

  // Value is kept across stop; only reset clears it.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pot_ref_ff <= dmi_pkg::DMI_POT_RST;
    end else if (clk_en) begin
      pot_ref_ff <= nxt_pot_ref;
    end
  end

endmodule : dmi_pot_ref
`default_nettype wire

//--- dmi_decoder_sva.sv
// Port-level checker of the drive macro input decoder.
`timescale 1ns/10ps
`default_nettype none
module dmi_decoder_sva (
  // Clock, reset and enable.
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  // Configuration and status.
  input wire logic [2:0] macro_sel,
  input wire logic vector_ctrl,
  input wire logic [1:0] safe_torque_off_inputs,
  input wire logic [15:0] const_freq1,
  input wire logic [15:0] const_speed1,
  input wire logic [15:0] freq_acc_time1,
  input wire logic [15:0] freq_acc_time2,
  input wire logic [15:0] speed_acc_time1,
  input wire logic [15:0] speed_acc_time2,
  input wire logic drive_ready,
  input wire logic motor_running,
  input wire logic drive_fault,
  // Decoder outputs.
  input wire logic run_cmd_ff,
  input wire logic [1:0] ref_src_ff,
  input wire logic [15:0] reference_ff,
  input wire logic ramp_set2_ff,
  input wire logic [15:0] acc_time_ff,
  input wire logic ready_relay,
  input wire logic running_relay,
  input wire logic fault_relay
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  // Three calm cycles allow for the output register behind the gating; the safe torque off inputs have no synchroniser.
  sequence sto_open_s;
    clk_en && safe_torque_off_inputs != 2'h3;
  endsequence
  sequence ramp_calm_s;
    clk_en && $stable(ramp_set2_ff) && $stable(vector_ctrl);
  endsequence
  sequence const1_calm_s;
    clk_en && ref_src_ff == 2'h1 && $stable(ref_src_ff) && $stable(vector_ctrl);
  endsequence
  sto_hold_a: assert property (sto_open_s [*3] |-> !run_cmd_ff)
    else $error("run while a safe torque off circuit is open");
  run_rise_a: assert property ($rose(run_cmd_ff) |-> $past(safe_torque_off_inputs) == 2'h3)
    else $error("run rose with a safe torque off circuit open");
  macro_bad_a: assert property ((clk_en && macro_sel > 3'h3) [*3] |-> !run_cmd_ff)
    else $error("run under an unknown macro code");
  ready_follow_a: assert property (clk_en |=> ready_relay == $past(drive_ready))
    else $error("ready relay does not follow readiness");
  running_follow_a: assert property (clk_en |=> running_relay == $past(motor_running))
    else $error("running relay does not follow running state");
  fault_invert_a: assert property (clk_en |=> fault_relay == !$past(drive_fault))
    else $error("fault relay is not the inverted fault");
  ramp_pick_a: assert property (ramp_calm_s [*4] |-> acc_time_ff == (vector_ctrl ?
    (ramp_set2_ff ? speed_acc_time2 : speed_acc_time1) :
    (ramp_set2_ff ? freq_acc_time2 : freq_acc_time1)))
    else $error("acceleration time does not match ramp set");
  const_pick_a: assert property (const1_calm_s [*4] |->
    reference_ff == (vector_ctrl ? const_speed1 : const_freq1))
    else $error("constant one reference mismatch");
  freeze_hold_a: assert property (!clk_en |=> $stable(run_cmd_ff) && $stable(reference_ff))
    else $error("state moved while the enable was low");
endmodule : dmi_decoder_sva
bind dmi_decoder dmi_decoder_sva u_sva (.clk_sys, .rstn, .clk_en, .macro_sel, .vector_ctrl,
  .safe_torque_off_inputs, .const_freq1, .const_speed1, .freq_acc_time1, .freq_acc_time2,
  .speed_acc_time1, .speed_acc_time2, .drive_ready, .motor_running, .drive_fault, .run_cmd_ff,
  .ref_src_ff, .reference_ff, .ramp_set2_ff, .acc_time_ff, .ready_relay, .running_relay,
  .fault_relay);
`default_nettype wire

//--- dmi_panel_model.sv
// Push-button panel model that drives the decoder digital inputs with contact chatter; the safe torque off inputs pass without it.
`timescale 1ns/10ps
`default_nettype none
module dmi_panel_model (
  // Clock.
  input wire logic clk_sys,
  // Requested levels.
  input wire logic [5:0] press,
  input wire logic [1:0] sto_req,
  // Terminals.
  output logic [5:0] di_pin,
  output logic [1:0] sto_pin
);
  logic [5:0] prev_ff = 6'h00;
  logic [5:0] chg_ff = 6'h00;
  logic [4:0] bounce_ff = 5'h00;
  // A changed contact chatters for 24 cycles, so the decoder must filter it.
  always_ff @(posedge clk_sys) begin
    prev_ff <= press;
    if (press != prev_ff) begin
      bounce_ff <= 5'h18;
      chg_ff <= press ^ prev_ff;
    end else if (bounce_ff != 5'h00) begin
      bounce_ff <= bounce_ff - 5'h01;
    end
    di_pin <= press ^ (bounce_ff[1] ? chg_ff : 6'h00);
    sto_pin <= sto_req;
  end
endmodule : dmi_panel_model
`default_nettype wire

//--- dmi_decoder_tb.sv
// Self-checking testbench of the drive macro input decoder.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module dmi_decoder_tb;
  localparam int SETTLE = 140;
  logic clk_sys = 1'b0, rstn = 1'b0, clk_en = 1'b0, vector_ctrl = 1'b0;
  logic [2:0] macro_sel = 3'h0;
  logic [5:0] press = 6'h00, di_pin;
  logic [1:0] sto_req = 2'h3, safe_torque_off_inputs, ref_src_ff;
  logic drive_ready = 1'b0, motor_running = 1'b0, drive_fault = 1'b0;
  logic [15:0] analog_reference_input, const_freq1, const_freq2, const_freq3, const_speed1;
  logic [15:0] const_speed2, const_speed3, freq_acc_time1, freq_dec_time1, freq_acc_time2;
  logic [15:0] freq_dec_time2, speed_acc_time1, speed_dec_time1, speed_acc_time2;
  logic [15:0] speed_dec_time2, reference_ff, acc_time_ff, dec_time_ff, pot = 16'h0000;
  logic [15:0] pot_step_period = 16'h0009, pot_step_size = 16'h0040;
  logic [15:0] pot_ref_min = 16'h0100, pot_ref_max = 16'h0400;
  logic run_cmd_ff, reverse_ff, ramp_set2_ff, ready_relay, running_relay, fault_relay;
  logic [15:0] cv [2][4];
  logic [15:0] rt [2][2][2];
  logic [31:0] lfsr = 32'hA721;
  bit latch = 0;
  int mismatches = 0, total_checks = 0;
  wire digital_input_one = di_pin[0];
  wire digital_input_two = di_pin[1];
  wire digital_input_three = di_pin[2];
  wire digital_input_four = di_pin[3];
  wire digital_input_five = di_pin[4];
  wire digital_input_six = di_pin[5];
  ////////////////////////////////////////
  // Decoder, its terminal panel and the clock.
  dmi_decoder dut (.clk_sys, .rstn, .clk_en, .macro_sel, .vector_ctrl, .digital_input_one,
    .digital_input_two, .digital_input_three, .digital_input_four, .digital_input_five,
    .digital_input_six, .safe_torque_off_inputs, .analog_reference_input, .const_freq1,
    .const_freq2, .const_freq3, .const_speed1, .const_speed2, .const_speed3, .freq_acc_time1,
    .freq_dec_time1, .freq_acc_time2, .freq_dec_time2, .speed_acc_time1, .speed_dec_time1,
    .speed_acc_time2, .speed_dec_time2, .pot_step_period, .pot_step_size, .pot_ref_min,
    .pot_ref_max, .drive_ready, .motor_running, .drive_fault, .run_cmd_ff, .reverse_ff,
    .ref_src_ff, .reference_ff, .ramp_set2_ff, .acc_time_ff, .dec_time_ff, .ready_relay,
    .running_relay, .fault_relay);
  dmi_panel_model panel (.clk_sys, .press, .sto_req, .di_pin, .sto_pin(safe_torque_off_inputs));
  always #5 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  function automatic logic [15:0] rnd16();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[15:0];
  endfunction : rnd16
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  // Reference model: expected outputs from the settled terminal levels.
  task automatic check_all();
    int code;
    bit run_e;
    bit rev_e;
    code = {press[3], press[2]};
    run_e = press[0];
    rev_e = press[1];
    if (macro_sel == 3'h1) begin
      code = {press[4], press[3]};
      run_e = latch;
      rev_e = press[2];
    end else if (macro_sel == 3'h2) begin
      run_e = (press[0] ^ press[1]) & press[5];
      rev_e = press[1] & ~press[0];
    end else if (macro_sel == 3'h3) begin
      code = press[4];
      run_e = press[0] & press[5];
    end
    if (sto_req != 2'h3 || macro_sel > 3'h3) run_e = 0;
    `CHK("run", run_e, run_cmd_ff)
    `CHK("ready", drive_ready, ready_relay)
    `CHK("running", motor_running, running_relay)
    `CHK("fault", ~drive_fault, fault_relay)
    if (macro_sel > 3'h3) return;
    if (code == 0) cv[vector_ctrl][0] = (macro_sel == 3'h3) ? pot : analog_reference_input;
    `CHK("reverse", rev_e, reverse_ff)
    `CHK("source", 2'(code), ref_src_ff)
    `CHK("reference", cv[vector_ctrl][code], reference_ff)
    if (macro_sel == 3'h1 || macro_sel == 3'h3) return;
    `CHK("ramp", press[4], ramp_set2_ff)
    `CHK("acc", rt[vector_ctrl][press[4]][0], acc_time_ff)
    `CHK("dec", rt[vector_ctrl][press[4]][1], dec_time_ff)
  endtask : check_all
  // Changes of mode clear the three-wire latch as the decoder does on leaving it.
  task automatic set_mode(input logic [2:0] m, input logic v, input logic [1:0] s);
    if (m != 3'h1) latch = 0;
    macro_sel <= m;
    vector_ctrl <= v;
    sto_req <= s;
    @(posedge clk_sys);
  endtask : set_mode
  // Pulse edges are tracked here; a stop edge beats a start edge in the same step.
  task automatic apply(input logic [5:0] p, input int wait_n);
    logic [5:0] rise;
    rise = p & ~press;
    if (macro_sel == 3'h1 && rise[1]) latch = 0;
    else if (macro_sel == 3'h1 && rise[0] && sto_req == 2'h3) latch = 1;
    press <= p;
    {drive_ready, motor_running, drive_fault} <= 3'(rnd16());
    repeat (wait_n) @(posedge clk_sys);
    check_all();
  endtask : apply
  ////////////////////////////////////////
  // Bounded run time; a hang is reported as a failure.
  initial begin
    repeat (90000) @(posedge clk_sys);
    mismatches++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    logic [15:0] r;
    logic [5:0] p;
    analog_reference_input = rnd16();
    {const_freq1, const_freq2, const_freq3} = {rnd16(), rnd16(), rnd16()};
    {const_speed1, const_speed2, const_speed3} = {rnd16(), rnd16(), rnd16()};
    {freq_acc_time1, freq_dec_time1} = {rnd16(), rnd16()};
    {freq_acc_time2, freq_dec_time2} = {rnd16(), rnd16()};
    {speed_acc_time1, speed_dec_time1, speed_acc_time2} = {rnd16(), rnd16(), rnd16()};
    speed_dec_time2 = rnd16();
    cv = '{'{16'h0, const_freq1, const_freq2, const_freq3},
      '{16'h0, const_speed1, const_speed2, const_speed3}};
    rt = '{'{'{freq_acc_time1, freq_dec_time1}, '{freq_acc_time2, freq_dec_time2}},
      '{'{speed_acc_time1, speed_dec_time1}, '{speed_acc_time2, speed_dec_time2}}};
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    clk_en <= 1'b1;
    @(posedge clk_sys);
    // Sweep macro codes 0 to 4 with random terminal patterns; unknown code 4 must not run.
    for (int i = 0; i < 45; i++) begin
      r = rnd16();
      if (i % 5 == 3) apply(press & 6'h33, SETTLE);
      set_mode(3'(i % 5), r[0], (i % 5 != 1 && r[2:1] == 2'h0) ? r[4:3] : 2'h3);
      p = r[10:5];
      if (i % 5 == 3) p[3:2] = 2'h0;
      apply(p, SETTLE);
      if (i % 5 == 1) apply(p & 6'h3C, SETTLE);
    end
    // Potentiometer: ramp to each limit, hold, stop, constant override, resume.
    apply(6'h00, SETTLE);
    set_mode(3'h3, 1'b0, 2'h3);
    pot = pot_ref_max;
    apply(6'h25, 400);
    apply(6'h2D, 200);
    pot = pot_ref_min;
    apply(6'h29, 400);
    apply(6'h00, 200);
    apply(6'h31, 200);
    apply(6'h21, SETTLE);
    // Three-wire: a start pulse latches and outlives its release, a stop pulse drops it.
    set_mode(3'h1, 1'b0, 2'h3);
    apply(6'h00, SETTLE);
    apply(6'h01, SETTLE);
    apply(6'h04, SETTLE);
    apply(6'h06, SETTLE);
    // A start pulse while a safe torque off circuit is open is not remembered.
    set_mode(3'h1, 1'b0, 2'h1);
    apply(6'h01, SETTLE);
    set_mode(3'h1, 1'b0, 2'h3);
    apply(6'h01, SETTLE);
    // A press shorter than the filter time must not start the motor.
    set_mode(3'h0, 1'b1, 2'h3);
    apply(6'h00, SETTLE);
    press <= 6'h01;
    repeat (50) @(posedge clk_sys);
    press <= 6'h00;
    repeat (70) @(posedge clk_sys);
    `CHK("glitch run", 1'b0, run_cmd_ff)
    apply(6'h00, SETTLE);
    // With the enable low nothing moves; after release the start takes effect.
    set_mode(3'h2, 1'b1, 2'h3);
    apply(6'h00, SETTLE);
    clk_en <= 1'b0;
    press <= 6'h21;
    repeat (200) @(posedge clk_sys);
    clk_en <= 1'b1;
    apply(6'h21, SETTLE);
    end_of_test();
  end
endmodule : dmi_decoder_tb
`default_nettype wire
